// >>> dv/paf_override_monitor.sv
// port checks for the override block
`timescale 1ns/1ps
`default_nettype none
module paf_override_monitor (
    input wire       clock,
    input wire       rst,
    input wire [7:0] portb_dir,
    input wire [7:0] portb_latch,
    input wire [7:0] portd_pin,
    input wire [7:0] portb_oe_n,
    input wire [7:0] portb_pullup,
    input wire [7:0] portd_oe_n,
    input wire [7:0] portb_dir_rd,
    input wire [7:0] portb_latch_rd,
    input wire       pull_up_disable,
    input wire       async_timer_select,
    input wire       external_clock_input_select,
    input wire       spi_enable,
    input wire       spi_master,
    input wire       usart_tx_enable,
    input wire       usart_rx_enable,
    input wire       osc_out_mode,
    input wire       osc_in_mode,
    input wire       external_irq0_input,
    input wire       pin_change_source18
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    wire slave = spi_enable & ~spi_master;
    a_osc_pin_modes:
        assert property (osc_in_mode == async_timer_select && osc_out_mode
            == (async_timer_select & ~external_clock_input_select))
        else $error("clock pin mode wrong");
    a_pb7_reads_zero:
        assert property (!$past(rst) |-> {portb_dir_rd[7], portb_latch_rd[7]}
            == $past({portb_dir[7], portb_latch[7]} & {2{~osc_out_mode}}))
        else $error("pb7 readback wrong");
    a_pb6_reads_zero:
        assert property (!$past(rst) |-> {portb_dir_rd[6], portb_latch_rd[6]}
            == $past({portb_dir[6], portb_latch[6]} & {2{~osc_in_mode}}))
        else $error("pb6 readback wrong");
    a_spi_slave_in:
        assert property (slave |-> portb_oe_n[5] && portb_oe_n[3])
        else $error("spi slave pin not input");
    a_spi_master_in:
        assert property (spi_enable && spi_master |-> portb_oe_n[4]
            && portb_oe_n[5] == ~portb_dir[5])
        else $error("spi master pins wrong");
    a_spi_pullup_kept:
        assert property (slave |->
            portb_pullup[5] == (portb_latch[5] & ~pull_up_disable))
        else $error("forced sck pull-up wrong");
    a_usart_pin_force:
        assert property ((usart_tx_enable |-> !portd_oe_n[1])
            and (usart_rx_enable |-> portd_oe_n[0]))
        else $error("usart pin direction wrong");
    a_irq0_latency:
        assert property (!$past(rst) && !$past(rst, 2) && !$past(rst, 3) |->
            {external_irq0_input, pin_change_source18}
            == {2{$past(portd_pin[2], 3)}})
        else $error("pd2 level not delivered");
endmodule // paf_override_monitor
bind paf_override paf_override_monitor mon (.*);
`default_nettype wire

// >>> dv/paf_pad_model.sv
// pad model: peripherals set the level where the block does not drive
`timescale 1ns/1ps
`default_nettype none
module paf_pad_model #(parameter int W = 8) (
    input  wire logic [W-1:0] drive,
    input  wire logic [W-1:0] oe_n,
    input  wire logic [W-1:0] ext,
    output logic      [W-1:0] pad
);
    // the far side never fights the block's own drive
    assign pad = (~oe_n & drive) | (oe_n & ext);
endmodule // paf_pad_model
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the override block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock = 1'b0, rst = 1'b1;
    logic [14:0] c = '0;
    logic [7:0] portb_dir = '0, portb_latch = '0, portd_dir = '0, bx = '0;
    logic [7:0] portd_latch = '0, dx = '0, e;
    logic [3:0] portc_dir = '0, portc_latch = '0, portc_pc_mask = '0, cx = '0;
    logic [3:0] analog_ch_digital_disable = '0;
    logic [7:4] portd_pc_mask = '0;
    logic [31:0] s = 32'h3a, w, r;
    logic sl, ms, oo;
    logic [31:0] q[$];
    int miscompares = 0, check_count = 0;
    event look;
    wire pull_up_disable, async_timer_select, external_clock_input_select,
        spi_enable, spi_master, usart_tx_enable, usart_rx_enable,
        usart_mode_select, usart_sync_clock, timer0_cmp_a_enable,
        timer0_compare_a_out, timer0_cmp_b_enable, timer0_compare_b_out,
        pin_change_group1_enable, pin_change_group2_enable;
    assign {pin_change_group2_enable, pin_change_group1_enable,
        timer0_compare_b_out, timer0_cmp_b_enable, timer0_compare_a_out,
        timer0_cmp_a_enable, usart_sync_clock, usart_mode_select,
        usart_rx_enable, usart_tx_enable, spi_master, spi_enable,
        external_clock_input_select, async_timer_select, pull_up_disable} = c;
    wire [7:0] portb_pin, portd_pin, portb_drive, portb_oe_n, portb_pullup,
        portd_drive, portd_oe_n, portd_pullup, portb_dir_rd, portb_latch_rd,
        portb_input_rd, portd_input_rd;
    wire [3:0] portc_pin, portc_oe_n, portc_pullup, portc_input_rd;
    wire osc_out_mode, osc_in_mode, timer0_count_input, timer1_count_input,
        usart_clock_input, external_irq0_input, pin_change_source18;
    paf_pad_model pb (.drive(portb_drive), .oe_n(portb_oe_n), .ext(bx),
        .pad(portb_pin));
    paf_pad_model pd (.drive(portd_drive), .oe_n(portd_oe_n), .ext(dx),
        .pad(portd_pin));
    paf_pad_model #(.W(4)) pc (.drive(4'h0), .oe_n(portc_oe_n), .ext(cx),
        .pad(portc_pin));
    paf_override dut (.*);
    function automatic logic [31:0] xs();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [7:0] seen(input logic [7:0] k);
        case (k)
            0: seen = {osc_out_mode, osc_in_mode, portb_oe_n[5:3],
                portd_oe_n[1:0], 1'b0};
            1: seen = {portb_pullup[5], portd_pullup[0], portd_drive[6:4],
                portc_input_rd[0], external_irq0_input, pin_change_source18};
            2: seen = {portb_dir_rd[7:6], portb_latch_rd[7:6],
                portb_input_rd[7:6], 2'h0};
            4: seen = {portb_drive[7:6], portb_oe_n[7:6],
                portb_pullup[7:6], portc_oe_n[0], portc_pullup[0]};
            default: seen = {portd_input_rd[4], timer0_count_input,
                usart_clock_input, timer1_count_input, 4'h0};
        endcase
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic note(input logic [7:0] k, x, m);
        q.push_back({8'h0, m, x & m, k});
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scoreboard: every queued note, oldest first, against the settled outputs
    // ------------------------------------------------------------
    always @(look) begin
        while (q.size() > 0) begin
            w = q.pop_front();
            check(seen(w[7:0]) & w[23:16], w[15:8]);
        end
    end
    initial forever #10 clock = ~clock;
    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end
    // ------------------------------------------------------------
    // random configurations; pads pd2, pd4, pd5 and pc0 stay undriven
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(negedge clock);
        rst = 1'b0;
        for (int i = 0; i < 200; i++) begin
            {portb_dir, portb_latch, portd_latch, bx} = xs();
            {portd_dir, dx, c, cx[0]} = xs();
            r = xs();
            {portc_dir, portc_latch, portc_pc_mask, portd_pc_mask,
                analog_ch_digital_disable, cx[3:1]} = r[22:0];
            portd_dir[5:4] = 2'h0;
            portd_dir[2] = 1'b0;
            portc_dir[0] = 1'b0;
            // look after the third edge, before the next stimulus lands
            repeat (3) @(negedge clock);
            sl = c[3] & ~c[4];
            ms = c[3] & c[4];
            oo = c[1] & ~c[2];
            note(8'h00, {oo, c[1], sl | ~portb_dir[5], ms | ~portb_dir[4],
                sl | ~portb_dir[3], ~c[5] & ~portd_dir[1],
                c[6] | ~portd_dir[0], 1'b0}, 8'hff);
            e[7] = ~c[0] & portb_latch[5] & ~(portb_dir[5] & ~sl);
            e[6] = ~c[0] & portd_latch[0] & ~(portd_dir[0] & ~c[6]);
            e[5:4] = {c[9] ? c[10] : portd_latch[6],
                c[11] ? c[12] : portd_latch[5]};
            e[3] = c[7] ? c[8] : portd_latch[4];
            e[2] = cx[0] & (portc_pc_mask[0] & c[13]
                | ~analog_ch_digital_disable[0]);
            e[1:0] = {2{dx[2]}};
            note(8'h01, e, 8'hff);
            note(8'h02, {portb_dir[7] & ~oo, portb_dir[6] & ~c[1],
                portb_latch[7] & ~oo, portb_latch[6] & ~c[1], 4'h0},
                {4'hf, oo, c[1], 2'h0});
            note(8'h03, {{3{dx[4]}}, dx[5], 4'h0}, 8'hf0);
            e = {~oo & portb_latch[7], ~c[1] & portb_latch[6],
                oo | ~portb_dir[7], c[1] | ~portb_dir[6],
                ~oo & ~c[0] & portb_latch[7] & ~portb_dir[7],
                ~c[1] & ~c[0] & portb_latch[6] & ~portb_dir[6],
                ~portc_dir[0], ~c[0] & portc_latch[0] & ~portc_dir[0]};
            note(8'h04, e, 8'hff);
            -> look;
            @(negedge clock);
        end
        print_verdict();
    end
endmodule // testbench
`default_nettype wire

// >>> include/paf_regs.vh
// constants for the port alternate-function override block
`ifndef PAF_REGS_VH
`define PAF_REGS_VH
// pin positions inside each 8-bit port
`define PAF_PB_OSC_OUT   3'd7
`define PAF_PB_OSC_IN    3'd6
`define PAF_PB_SCK       3'd5
`define PAF_PB_MISO      3'd4
`define PAF_PB_MOSI      3'd3
`define PAF_PD_TXD       3'd1
`define PAF_PD_RXD       3'd0
`define PAF_PD_IRQ0      3'd2
`define PAF_PD_TIMER0_COMPARE_A_OUT      3'd6
`define PAF_PD_TIMER0_COMPARE_B_OUT      3'd5
`define PAF_PD_XCK       3'd4
// reset values of the registered outputs
`define PAF_RST_BYTE     8'h00
`define PAF_RST_BIT      1'b0
`define PAF_RST_NIB      4'h0
`endif

// >>> rtl/paf_override.v
// port b/c/d alternate-function override logic
`timescale 1ns/1ps
`default_nettype none
`include "paf_regs.vh"

// Operation
// - pb7 becomes oscillator output when async, no extclk
// - pb7 clock pin: dir, latch, input read zero
// - pb6 becomes oscillator input when async selected
// - pb6 clock pin: dir, latch, input read zero
// - spi slave forces sck input
// - spi master forces miso input
// - spi slave forces mosi input
// - forced spi input keeps latch-driven pull-up
// - port c 3..0 input-enable override from mask, adc
// - usart transmitter forces pd1 output
// - usart receiver forces pd0 input, pull-up kept
// - port d 6..4 output overrides from timers, xck
// - port d 7..4 input override, count inputs fed
// - pd2 level feeds irq0 and pin-change 18
module paf_override (
    input  wire       clock,
    input  wire       rst,
    input  wire [7:0] portb_dir,
    input  wire [7:0] portb_latch,
    input  wire [7:0] portb_pin,
    input  wire [3:0] portc_dir,
    input  wire [3:0] portc_latch,
    input  wire [3:0] portc_pin,
    input  wire [7:0] portd_dir,
    input  wire [7:0] portd_latch,
    input  wire [7:0] portd_pin,
    input  wire       pull_up_disable,
    input  wire       async_timer_select,
    input  wire       external_clock_input_select,
    input  wire       spi_enable,
    input  wire       spi_master,
    input  wire       usart_tx_enable,
    input  wire       usart_rx_enable,
    input  wire       usart_mode_select,
    input  wire       usart_sync_clock,
    input  wire       timer0_cmp_a_enable,
    input  wire       timer0_compare_a_out,
    input  wire       timer0_cmp_b_enable,
    input  wire       timer0_compare_b_out,
    input  wire [3:0] portc_pc_mask,
    input  wire [7:4] portd_pc_mask,
    input  wire       pin_change_group1_enable,
    input  wire       pin_change_group2_enable,
    input  wire [3:0] analog_ch_digital_disable,
    output wire [7:0] portb_drive,
    output wire [7:0] portb_oe_n,
    output wire [7:0] portb_pullup,
    output wire [3:0] portc_oe_n,
    output wire [3:0] portc_pullup,
    output wire [7:0] portd_drive,
    output wire [7:0] portd_oe_n,
    output wire [7:0] portd_pullup,
    output reg  [7:0] portb_dir_rd,
    output reg  [7:0] portb_latch_rd,
    output reg  [7:0] portb_input_rd,
    output reg  [3:0] portc_input_rd,
    output reg  [7:0] portd_input_rd,
    output wire       osc_out_mode,
    output wire       osc_in_mode,
    output reg        timer0_count_input,
    output reg        timer1_count_input,
    output reg        usart_clock_input,
    output reg        external_irq0_input,
    output reg        pin_change_source18
);

// ---------------------------------------------------------------
// synchronisers
// ---------------------------------------------------------------
reg [7:0] pb_s1_q, pb_s2_q;
reg [3:0] pc_s1_q, pc_s2_q;
reg [7:0] pd_s1_q, pd_s2_q;
always @(posedge clock) begin
    if (rst) begin
        pb_s1_q <= `PAF_RST_BYTE;
        pb_s2_q <= `PAF_RST_BYTE;
        pc_s1_q <= `PAF_RST_NIB;
        pc_s2_q <= `PAF_RST_NIB;
        pd_s1_q <= `PAF_RST_BYTE;
        pd_s2_q <= `PAF_RST_BYTE;
    end else begin
        pb_s1_q <= portb_pin;
        pb_s2_q <= pb_s1_q;
        pc_s1_q <= portc_pin;
        pc_s2_q <= pc_s1_q;
        pd_s1_q <= portd_pin;
        pd_s2_q <= pd_s1_q;
    end
end

// ---------------------------------------------------------------
// override signals per pin
// ---------------------------------------------------------------
reg [7:0] b_pullup_override_enable, b_puov, b_direction_override_enable, b_direction_override_value, b_out_value_override_enable, b_out_value_override_value;
reg [7:0] b_input_enable_override_enable, b_input_enable_override_value;
reg [7:0] d_pullup_override_enable, d_puov, d_direction_override_enable, d_direction_override_value, d_out_value_override_enable, d_out_value_override_value;
reg [7:0] d_input_enable_override_enable, d_input_enable_override_value;
reg [3:0] c_input_enable_override_enable, c_input_enable_override_value;

assign osc_out_mode = async_timer_select &
                      ~external_clock_input_select;
assign osc_in_mode  = async_timer_select;

always @* begin
    b_pullup_override_enable  = 8'h00;
    b_puov  = 8'h00;
    b_direction_override_enable  = 8'h00;
    b_direction_override_value  = 8'h00;
    b_out_value_override_enable  = 8'h00;
    b_out_value_override_value  = 8'h00;
    b_input_enable_override_enable = 8'h00;
    b_input_enable_override_value = 8'h00;
    // clock pins: no drive, no pull-up, input path cut
    if (osc_out_mode) begin
        b_pullup_override_enable[`PAF_PB_OSC_OUT]  = 1'b1;
        b_direction_override_enable[`PAF_PB_OSC_OUT]  = 1'b1;
        b_out_value_override_enable[`PAF_PB_OSC_OUT]  = 1'b1;
        b_input_enable_override_enable[`PAF_PB_OSC_OUT] = 1'b1;
    end
    if (osc_in_mode) begin
        b_pullup_override_enable[`PAF_PB_OSC_IN]  = 1'b1;
        b_direction_override_enable[`PAF_PB_OSC_IN]  = 1'b1;
        b_out_value_override_enable[`PAF_PB_OSC_IN]  = 1'b1;
        b_input_enable_override_enable[`PAF_PB_OSC_IN] = 1'b1;
    end
    // only direction is forced; pull-up stays with the latch
    b_direction_override_enable[`PAF_PB_SCK]  = spi_enable & ~spi_master;
    b_direction_override_enable[`PAF_PB_MISO] = spi_enable & spi_master;
    b_direction_override_enable[`PAF_PB_MOSI] = spi_enable & ~spi_master;
    // pb3 compare output needs its direction bit set by software
end

always @* begin
    c_input_enable_override_enable = (portc_pc_mask & {4{pin_change_group1_enable}}) |
              analog_ch_digital_disable;
    c_input_enable_override_value = portc_pc_mask & {4{pin_change_group1_enable}};
end

always @* begin
    d_pullup_override_enable  = 8'h00;
    d_puov  = 8'h00;
    d_direction_override_enable  = 8'h00;
    d_direction_override_value  = 8'h00;
    d_out_value_override_enable  = 8'h00;
    d_out_value_override_value  = 8'h00;
    d_input_enable_override_enable = 8'h00;
    d_input_enable_override_value = 8'h00;
    d_direction_override_enable[`PAF_PD_TXD] = usart_tx_enable;
    d_direction_override_value[`PAF_PD_TXD] = 1'b1;
    d_direction_override_enable[`PAF_PD_RXD] = usart_rx_enable;
    d_out_value_override_enable[`PAF_PD_TIMER0_COMPARE_A_OUT] = timer0_cmp_a_enable;
    d_out_value_override_value[`PAF_PD_TIMER0_COMPARE_A_OUT] = timer0_compare_a_out;
    d_out_value_override_enable[`PAF_PD_TIMER0_COMPARE_B_OUT] = timer0_cmp_b_enable;
    d_out_value_override_value[`PAF_PD_TIMER0_COMPARE_B_OUT] = timer0_compare_b_out;
    d_out_value_override_enable[`PAF_PD_XCK]  = usart_mode_select;
    d_out_value_override_value[`PAF_PD_XCK]  = usart_sync_clock;
    d_input_enable_override_enable[7:4] = portd_pc_mask & {4{pin_change_group2_enable}};
    d_input_enable_override_value[7:4] = 4'hf;
    // pd3 timer2 compare b waits on software direction bit
end

// ---------------------------------------------------------------
// apply overrides
// ---------------------------------------------------------------
wire [7:0] b_dir = (b_direction_override_enable & b_direction_override_value) | (~b_direction_override_enable & portb_dir);
wire [7:0] b_val = (b_out_value_override_enable & b_out_value_override_value) | (~b_out_value_override_enable & portb_latch);
// effective direction, so a forced input keeps the latch pull-up
wire [7:0] b_pu  = (b_pullup_override_enable & b_puov) |
                   (~b_pullup_override_enable & portb_latch & ~b_dir &
                    {8{~pull_up_disable}});
wire [7:0] b_die = (b_input_enable_override_enable & b_input_enable_override_value) | ~b_input_enable_override_enable;
assign portb_drive  = b_val;
assign portb_oe_n   = ~b_dir;
assign portb_pullup = b_pu & ~b_dir;

wire [3:0] c_die = (c_input_enable_override_enable & c_input_enable_override_value) | ~c_input_enable_override_enable;
assign portc_oe_n   = ~portc_dir;
assign portc_pullup = portc_latch & ~portc_dir &
                      {4{~pull_up_disable}};

wire [7:0] d_dir = (d_direction_override_enable & d_direction_override_value) | (~d_direction_override_enable & portd_dir);
wire [7:0] d_val = (d_out_value_override_enable & d_out_value_override_value) | (~d_out_value_override_enable & portd_latch);
wire [7:0] d_pu  = (d_pullup_override_enable & d_puov) |
                   (~d_pullup_override_enable & portd_latch & ~d_dir &
                    {8{~pull_up_disable}});
wire [7:0] d_die = (d_input_enable_override_enable & d_input_enable_override_value) | ~d_input_enable_override_enable;
assign portd_drive  = d_val;
assign portd_oe_n   = ~d_dir;
assign portd_pullup = d_pu & ~d_dir;

// ---------------------------------------------------------------
// readback and peripheral inputs (registered)
// ---------------------------------------------------------------
// clock pins hide port state so software cannot misuse them
wire [7:0] b_hide = {osc_out_mode, osc_in_mode, 6'h00};
always @(posedge clock) begin
    if (rst) begin
        portb_dir_rd        <= `PAF_RST_BYTE;
        portb_latch_rd      <= `PAF_RST_BYTE;
        portb_input_rd      <= `PAF_RST_BYTE;
        portc_input_rd      <= `PAF_RST_NIB;
        portd_input_rd      <= `PAF_RST_BYTE;
        timer0_count_input  <= `PAF_RST_BIT;
        timer1_count_input  <= `PAF_RST_BIT;
        usart_clock_input   <= `PAF_RST_BIT;
        external_irq0_input <= `PAF_RST_BIT;
        pin_change_source18 <= `PAF_RST_BIT;
    end else begin
        portb_dir_rd   <= portb_dir & ~b_hide;
        portb_latch_rd <= portb_latch & ~b_hide;
        portb_input_rd <= pb_s2_q & b_die & ~b_hide;
        portc_input_rd <= pc_s2_q & c_die;
        portd_input_rd <= pd_s2_q & d_die;
        timer1_count_input  <= pd_s2_q[5] & d_die[5];
        timer0_count_input  <= pd_s2_q[4] & d_die[4];
        usart_clock_input   <= pd_s2_q[4] & d_die[4];
        external_irq0_input <= pd_s2_q[`PAF_PD_IRQ0];
        pin_change_source18 <= pd_s2_q[`PAF_PD_IRQ0];
    end
end

endmodule // paf_override

`default_nettype wire
